// File: hw/cpm_cfg.svh
// constants of the can parameter map: identifier fields, prefixes, groups,
// field positions, reset values and timing
// assumes a 29-bit extended identifier and an 8-byte data field
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

// identifier: [28:24] priority, [23:8] group number, [7:0] source address
`define CPM_PRIO 5'h18
`define CPM_HOST_SA 8'h70
`define CPM_DEV_SA 8'h00
`define CPM_ID_PRIO_LSB 24
`define CPM_ID_PGN_LSB 8

// two-byte prefixes, values arbitrary
`define CPM_TX_PFX0 8'h5A
`define CPM_TX_PFX1 8'h3C
`define CPM_RX_PFX0 8'h5B
`define CPM_RX_PFX1 8'h3C

// group numbers
`define CPM_PGN_SPEED 16'hFF90
`define CPM_PGN_MIN_RPM 16'hFF91
`define CPM_PGN_MAX_RPM 16'hFF92
`define CPM_PGN_ANALOG 16'hFF93
`define CPM_PGN_HOURS 16'hFF94
`define CPM_PGN_STATE 16'hFF95
`define CPM_PGN_RUN 16'hFF96
`define CPM_PGN_MODE 16'hFF97
`define CPM_PGN_MAN_ONLY 16'hFF98
`define CPM_PGN_PRE1 16'hFF99
`define CPM_PGN_SAVE 16'hFFBB
`define CPM_GROUPS 4'hA

// field positions within the data field, bit 0 = lsb of byte 0
`define CPM_FLD0_LSB 16
`define CPM_FLD1_LSB 32
`define CPM_FLD2_LSB 48
`define CPM_TMR_LSB 24
`define CPM_BIT_RUN 16
`define CPM_BIT_MODE 16
`define CPM_BIT_MAN_ONLY 17
`define CPM_BIT_PRE1 18
`define CPM_BIT_SAVE 16

// reset values of writable settings
`define CPM_RST_MIN_RPM 16'h0000
`define CPM_RST_MAX_RPM 16'hFFFF

// broadcast period
`define CPM_PERIOD_NS 1000000000
`define CPM_CLK_NS 25

`endif

// File: hw/cpm_pkg.sv
// types shared by both ends of the can parameter map
// assumes cpm_cfg.svh for all numeric constants
package cpm_pkg;
	typedef logic [28:0] cpm_id_type;
	typedef logic [63:0] cpm_data_type;
	typedef logic [15:0] cpm_pgn_type;
	typedef logic [47:0] cpm_payload_type;
	typedef enum logic [1:0] {
		CPM_IDLE = 2'b01,
		CPM_SEND = 2'b10
	} cpm_tx_state_type;
endpackage : cpm_pkg

// File: hw/cpm_link_if.sv
// frame-level link between the device end and the remote node
// assumes both ends share one clock; valid/ready handshake per frame
`timescale 1ns/1ps
`default_nettype none
interface cpm_link_if;
	import cpm_pkg::*;
	// device to remote
	logic d2h_valid;
	logic d2h_ready;
	cpm_id_type d2h_id;
	cpm_data_type d2h_data;
	// remote to device
	logic h2d_valid;
	logic h2d_ready;
	cpm_id_type h2d_id;
	cpm_data_type h2d_data;

	modport dev (
		output d2h_valid, d2h_id, d2h_data, h2d_ready,
		input d2h_ready, h2d_valid, h2d_id, h2d_data
	);
	modport host (
		input d2h_valid, d2h_id, d2h_data, h2d_ready,
		output d2h_ready, h2d_valid, h2d_id, h2d_data
	);
endinterface : cpm_link_if
`default_nettype wire

// File: hw/cpm_tick.sv
// periodic one-cycle tick, counting only while enabled
// assumes cycles is at least 2
`timescale 1ns/1ps
`default_nettype none
module cpm_tick #(
	parameter int unsigned CYCLES = 40000000
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// control
	input wire logic enable,
	output logic tick
);
	import cpm_pkg::*;

	logic [31:0] count_q;

	always_ff @(posedge clock) begin
		if (srst || !enable) begin
			count_q <= 32'h00000000;
			tick <= 1'b0;
		end else if (count_q == CYCLES - 1) begin
			count_q <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			count_q <= count_q + 32'h00000001;
			tick <= 1'b0;
		end
	end
endmodule : cpm_tick
`default_nettype wire

// File: hw/cpm_device.sv
// device end of the can parameter map: broadcasts status groups once a
// second and takes command and setpoint groups from the remote node
// assumes the can controller below delivers whole frames on the link
//
// Operation
// [R1] fields are raw integers, scale one, offset zero
// [R2] sent groups open with the outbound prefix
// [R3] remote writes reuse group, use inbound prefix
// [R4] remote frames carry priority 18 hex
// [R5] remote frames carry source address 70 hex
// [R6] save bit 16 set commits settings
// [R7] next save needs the bit back at zero
// [R8] broadcast all groups once per second
// [R9] silent and deaf while comms disabled
// [R10] writable minimum speed in bits 16-31
// [R11] writable maximum speed in bits 16-31
// [R12] voltage in tenths, bits 16-31, read-only
// [R13] oil pressure 32-47, temperature 48-63
// [R14] state code 16-23, state timer follows
// [R15] bit 16 auto run command, readable
// [R16] bit 16 selects manual or auto
// [R17] bit 17 locks operation to manual
// [R18] bit 18 prestart 1 auto-only option
// [R19] auto-only one gates prestart in manual
// [R20] writes to read-only groups are ignored
// [R21] multi-byte fields least significant byte first
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"
module cpm_device #(
	parameter int unsigned TICK_CYCLES = `CPM_PERIOD_NS / `CPM_CLK_NS
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// link
	cpm_link_if.dev link,
	// controller status
	input wire logic comm_enable,
	input wire logic [15:0] engine_rpm,
	input wire logic [15:0] target_rpm,
	input wire logic [15:0] volts_tenths,
	input wire logic [15:0] oil_kpa,
	input wire logic [15:0] engine_temp,
	input wire logic [31:0] engine_hours,
	input wire logic [15:0] fuel_level,
	input wire logic [7:0] state_code,
	input wire logic [15:0] state_timer,
	input wire logic prestart1_req,
	// settings and commands
	output logic [15:0] min_rpm_q,
	output logic [15:0] max_rpm_q,
	output logic run_cmd_q,
	output logic auto_mode_q,
	output logic manual_only_q,
	output logic pre1_auto_only_q,
	output logic auto_active_q,
	output logic run_active_q,
	output logic prestart1_out_q,
	output logic save_pulse_q
);
	import cpm_pkg::*;

	// ======================================================================
	// broadcast timing
	// ======================================================================
	logic tick;

	cpm_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.srst(srst),
		.enable(comm_enable),
		.tick(tick)
	);

	// ======================================================================
	// frame building
	// ======================================================================
	function automatic cpm_pgn_type pgn_of(input logic [3:0] idx);
		unique case (idx)
			4'h0: pgn_of = `CPM_PGN_SPEED;
			4'h1: pgn_of = `CPM_PGN_MIN_RPM;
			4'h2: pgn_of = `CPM_PGN_MAX_RPM;
			4'h3: pgn_of = `CPM_PGN_ANALOG;
			4'h4: pgn_of = `CPM_PGN_HOURS;
			4'h5: pgn_of = `CPM_PGN_STATE;
			4'h6: pgn_of = `CPM_PGN_RUN;
			4'h7: pgn_of = `CPM_PGN_MODE;
			4'h8: pgn_of = `CPM_PGN_MAN_ONLY;
			default: pgn_of = `CPM_PGN_PRE1;
		endcase
	endfunction : pgn_of

	function automatic cpm_data_type data_of(input logic [3:0] idx);
		cpm_data_type d;
		d = 64'h0000000000000000;
		d[7:0] = `CPM_TX_PFX0; // [R2]
		d[15:8] = `CPM_TX_PFX1; // [R2]
		// values go out unscaled, low byte in the lower byte slot
		unique case (idx) // [R1] [R21]
			4'h0: begin
				d[`CPM_FLD0_LSB +: 16] = engine_rpm;
				d[`CPM_FLD1_LSB +: 16] = target_rpm;
			end
			4'h1: d[`CPM_FLD0_LSB +: 16] = min_rpm_q; // [R10]
			4'h2: d[`CPM_FLD0_LSB +: 16] = max_rpm_q; // [R11]
			4'h3: begin
				d[`CPM_FLD0_LSB +: 16] = volts_tenths; // [R12]
				d[`CPM_FLD1_LSB +: 16] = oil_kpa; // [R13]
				d[`CPM_FLD2_LSB +: 16] = engine_temp; // [R13]
			end
			4'h4: begin
				d[`CPM_FLD0_LSB +: 32] = engine_hours;
				d[`CPM_FLD2_LSB +: 16] = fuel_level;
			end
			4'h5: begin
				d[`CPM_FLD0_LSB +: 8] = state_code; // [R14]
				d[`CPM_TMR_LSB +: 16] = state_timer; // [R14]
			end
			4'h6: d[`CPM_BIT_RUN] = run_cmd_q; // [R15]
			4'h7: d[`CPM_BIT_MODE] = auto_mode_q; // [R16]
			4'h8: d[`CPM_BIT_MAN_ONLY] = manual_only_q; // [R17]
			default: d[`CPM_BIT_PRE1] = pre1_auto_only_q; // [R18]
		endcase
		data_of = d;
	endfunction : data_of

	function automatic cpm_id_type id_of(input logic [3:0] idx);
		id_of = {`CPM_PRIO, pgn_of(idx), `CPM_DEV_SA};
	endfunction : id_of

	// ======================================================================
	// transmit sequencer
	// ======================================================================
	cpm_tx_state_type tx_state_q;
	logic [3:0] tx_idx_q;
	logic last_group;

	assign last_group = (tx_idx_q == `CPM_GROUPS - 4'h1);

	always_ff @(posedge clock) begin
		if (srst) begin
			tx_state_q <= CPM_IDLE;
			tx_idx_q <= 4'h0;
			link.d2h_valid <= 1'b0;
			link.d2h_id <= '0;
			link.d2h_data <= '0;
		end else begin
			unique case (tx_state_q)
				CPM_IDLE: begin
					if (tick && comm_enable) begin // [R8]
						tx_state_q <= CPM_SEND;
						tx_idx_q <= 4'h0;
						link.d2h_valid <= 1'b1;
						link.d2h_id <= id_of(4'h0);
						link.d2h_data <= data_of(4'h0);
					end
				end
				CPM_SEND: begin
					if (!comm_enable) begin // [R9]
						tx_state_q <= CPM_IDLE;
						link.d2h_valid <= 1'b0;
					end else if (link.d2h_ready) begin
						if (last_group) begin
							tx_state_q <= CPM_IDLE;
							link.d2h_valid <= 1'b0;
						end else begin
							tx_idx_q <= tx_idx_q + 4'h1;
							link.d2h_id <= id_of(tx_idx_q + 4'h1); // [R8]
							link.d2h_data <= data_of(tx_idx_q + 4'h1);
						end
					end
				end
			endcase
		end
	end

	// ======================================================================
	// receive filter
	// ======================================================================
	logic rx_take;
	cpm_pgn_type rx_pgn;
	cpm_data_type rx_data;

	assign rx_pgn = link.h2d_id[`CPM_ID_PGN_LSB +: 16];
	assign rx_data = link.h2d_data;
	assign rx_take = link.h2d_valid && link.h2d_ready && comm_enable // [R9]
		&& link.h2d_id[`CPM_ID_PRIO_LSB +: 5] == `CPM_PRIO // [R4]
		&& link.h2d_id[7:0] == `CPM_HOST_SA // [R5]
		&& rx_data[7:0] == `CPM_RX_PFX0 // [R3]
		&& rx_data[15:8] == `CPM_RX_PFX1; // [R3]

	always_ff @(posedge clock) begin
		if (srst) begin
			link.h2d_ready <= 1'b0;
		end else begin
			link.h2d_ready <= 1'b1;
		end
	end

	// ======================================================================
	// writable settings
	// ======================================================================
	always_ff @(posedge clock) begin
		if (srst) begin
			min_rpm_q <= `CPM_RST_MIN_RPM;
			max_rpm_q <= `CPM_RST_MAX_RPM;
			run_cmd_q <= 1'b0;
			auto_mode_q <= 1'b0;
			manual_only_q <= 1'b0;
			pre1_auto_only_q <= 1'b0;
		end else if (rx_take) begin
			case (rx_pgn)
				`CPM_PGN_MIN_RPM:
					min_rpm_q <= rx_data[`CPM_FLD0_LSB +: 16]; // [R10] [R21]
				`CPM_PGN_MAX_RPM:
					max_rpm_q <= rx_data[`CPM_FLD0_LSB +: 16]; // [R11] [R21]
				`CPM_PGN_RUN: run_cmd_q <= rx_data[`CPM_BIT_RUN]; // [R15]
				`CPM_PGN_MODE: auto_mode_q <= rx_data[`CPM_BIT_MODE]; // [R16]
				`CPM_PGN_MAN_ONLY:
					manual_only_q <= rx_data[`CPM_BIT_MAN_ONLY]; // [R17]
				`CPM_PGN_PRE1:
					pre1_auto_only_q <= rx_data[`CPM_BIT_PRE1]; // [R18]
				default: begin
					// read-only and unknown groups leave everything as is
					min_rpm_q <= min_rpm_q; // [R20]
				end
			endcase
		end
	end

	// ======================================================================
	// save command
	// ======================================================================
	logic save_armed_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			save_armed_q <= 1'b1;
			save_pulse_q <= 1'b0;
		end else begin
			save_pulse_q <= 1'b0;
			if (rx_take && rx_pgn == `CPM_PGN_SAVE) begin
				if (!rx_data[`CPM_BIT_SAVE]) begin
					save_armed_q <= 1'b1; // [R7]
				end else if (save_armed_q) begin
					save_pulse_q <= 1'b1; // [R6]
					save_armed_q <= 1'b0; // [R7]
				end
			end
		end
	end

	// ======================================================================
	// effective operating outputs
	// ======================================================================
	logic auto_eff;

	assign auto_eff = auto_mode_q && !manual_only_q; // [R17]

	always_ff @(posedge clock) begin
		if (srst) begin
			auto_active_q <= 1'b0;
			run_active_q <= 1'b0;
			prestart1_out_q <= 1'b0;
		end else begin
			auto_active_q <= auto_eff; // [R16] [R17]
			run_active_q <= run_cmd_q && auto_eff; // [R15]
			prestart1_out_q <= prestart1_req
				&& (auto_eff || !pre1_auto_only_q); // [R19]
		end
	end
endmodule : cpm_device
`default_nettype wire

// File: hw/cpm_host.sv
// remote node end of the can parameter map: sends write frames on command
// and hands each broadcast group to its user
// assumes the device end on the same clock across cpm_link_if
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"
module cpm_host (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// link
	cpm_link_if.host link,
	// write command
	input wire logic cmd_valid,
	input wire cpm_pkg::cpm_pgn_type cmd_pgn,
	input wire cpm_pkg::cpm_payload_type cmd_payload,
	output logic cmd_ready_q,
	// received groups
	output logic rx_strobe_q,
	output cpm_pkg::cpm_pgn_type rx_pgn_q,
	output cpm_pkg::cpm_payload_type rx_payload_q
);
	import cpm_pkg::*;

	// ======================================================================
	// write frames
	// ======================================================================
	always_ff @(posedge clock) begin
		if (srst) begin
			link.h2d_valid <= 1'b0;
			link.h2d_id <= '0;
			link.h2d_data <= '0;
			cmd_ready_q <= 1'b0;
		end else if (link.h2d_valid) begin
			if (link.h2d_ready) begin
				link.h2d_valid <= 1'b0;
				cmd_ready_q <= 1'b1;
			end
		end else if (cmd_valid && cmd_ready_q) begin
			link.h2d_valid <= 1'b1;
			cmd_ready_q <= 1'b0;
			link.h2d_id <= {`CPM_PRIO, cmd_pgn, `CPM_HOST_SA}; // [R4] [R5]
			link.h2d_data <= {cmd_payload, `CPM_RX_PFX1, `CPM_RX_PFX0}; // [R3]
		end else begin
			cmd_ready_q <= 1'b1;
		end
	end

	// ======================================================================
	// broadcast reception
	// ======================================================================
	always_ff @(posedge clock) begin
		if (srst) begin
			link.d2h_ready <= 1'b0;
			rx_strobe_q <= 1'b0;
			rx_pgn_q <= '0;
			rx_payload_q <= '0;
		end else begin
			link.d2h_ready <= 1'b1;
			rx_strobe_q <= 1'b0;
			if (link.d2h_valid && link.d2h_ready
				&& link.d2h_data[7:0] == `CPM_TX_PFX0
				&& link.d2h_data[15:8] == `CPM_TX_PFX1) begin // [R2]
				rx_strobe_q <= 1'b1;
				rx_pgn_q <= link.d2h_id[`CPM_ID_PGN_LSB +: 16];
				rx_payload_q <= link.d2h_data[63:16]; // [R21]
			end
		end
	end
endmodule : cpm_host
`default_nettype wire

// File: sim/cpm_link_checker.sv
// checker for the link that joins the device and remote ends
// assumes one clock and srst synchronous, active high
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"
module cpm_link_checker (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// device to remote
	input wire logic d2h_valid,
	input wire logic d2h_ready,
	input wire cpm_pkg::cpm_id_type d2h_id,
	input wire cpm_pkg::cpm_data_type d2h_data,
	// remote to device
	input wire logic h2d_valid,
	input wire logic h2d_ready,
	input wire cpm_pkg::cpm_id_type h2d_id,
	input wire cpm_pkg::cpm_data_type h2d_data
);
	import cpm_pkg::*;
	cpm_pgn_type pgn;
	logic take;
	assign pgn = d2h_id[23:8];
	assign take = d2h_valid && d2h_ready;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// ==========
	// broadcast
	property p_tx_prefix;
		d2h_valid |-> d2h_data[15:0] == {`CPM_TX_PFX1, `CPM_TX_PFX0};
	endproperty
	a_tx_prefix: assert property (p_tx_prefix)
		else $error("outbound prefix wrong");
	property p_first;
		$rose(d2h_valid) |-> pgn == `CPM_PGN_SPEED;
	endproperty
	a_first: assert property (p_first)
		else $error("burst does not open with the speed group");
	property p_next;
		take && pgn != `CPM_PGN_PRE1 |=>
			!d2h_valid || pgn == $past(pgn) + 16'h0001;
	endproperty
	a_next: assert property (p_next)
		else $error("burst groups out of order");
	property p_end;
		take && pgn == `CPM_PGN_PRE1 |=> !d2h_valid;
	endproperty
	a_end: assert property (p_end)
		else $error("burst runs past the last group");
	// ==========
	// writes
	property p_rx_prio;
		h2d_valid |-> h2d_id[28:24] == `CPM_PRIO;
	endproperty
	a_rx_prio: assert property (p_rx_prio)
		else $error("write priority wrong");
	property p_rx_sa;
		h2d_valid |-> h2d_id[7:0] == `CPM_HOST_SA;
	endproperty
	a_rx_sa: assert property (p_rx_sa)
		else $error("write source address wrong");
	property p_rx_prefix;
		h2d_valid |-> h2d_data[15:0] == {`CPM_RX_PFX1, `CPM_RX_PFX0};
	endproperty
	a_rx_prefix: assert property (p_rx_prefix)
		else $error("inbound prefix wrong");
	property p_one_frame;
		h2d_valid && h2d_ready |=> !h2d_valid;
	endproperty
	a_one_frame: assert property (p_one_frame)
		else $error("write frame sent twice");
endmodule : cpm_link_checker
`default_nettype wire

// File: sim/can_parameter_message_map_tb.sv
// bench: both ends joined, plus a second device fed by a driver
// that breaks the write rules; assumes the cpm_cfg.svh constants
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"
module can_parameter_message_map_tb;
	import cpm_pkg::*;
	localparam int unsigned TK = 50;
	// ==========
	// signals
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic comm_enable = 1'b0;
	logic prestart1_req = 1'b1;
	logic [15:0] engine_rpm = 16'h05DC;
	logic [15:0] target_rpm = 16'h0708;
	logic [15:0] volts_tenths = 16'h007D;
	logic [15:0] oil_kpa = 16'h00C8;
	logic [15:0] engine_temp = 16'h0055;
	logic [31:0] engine_hours = 32'h00012345;
	logic [15:0] fuel_level = 16'h0032;
	logic [7:0] state_code = 8'h10;
	logic [15:0] state_timer = 16'h0123;
	logic cmd_valid = 1'b0;
	cpm_pgn_type cmd_pgn = 16'h0000;
	cpm_payload_type cmd_payload = 48'h000000000000;
	logic [15:0] min_rpm_q, max_rpm_q, min_rpm_b;
	logic run_cmd_q, auto_mode_q, manual_only_q, pre1_auto_only_q;
	logic auto_active_q, run_active_q, prestart1_out_q, save_pulse_q;
	logic cmd_ready_q, rx_strobe_q;
	cpm_pgn_type rx_pgn_q;
	cpm_payload_type rx_payload_q;
	cpm_pgn_type rx_pgn[$];
	cpm_payload_type rx_pay[$];
	cpm_data_type wire93;
	int saves = 0;
	int errors = 0;
	int compares = 0;
	cpm_link_if link();
	cpm_link_if link_b();
	always #12.5 clock = ~clock;
	always @(posedge clock) begin
		if (rx_strobe_q === 1'b1) begin
			rx_pgn.push_back(rx_pgn_q);
			rx_pay.push_back(rx_payload_q);
		end
		if (save_pulse_q === 1'b1)
			saves++;
		if (link.d2h_valid && link.d2h_ready
			&& link.d2h_id[23:8] == `CPM_PGN_ANALOG)
			wire93 = link.d2h_data;
	end
	// ==========
	// instances
	cpm_device #(.TICK_CYCLES(TK)) cpm_device_inst (
		.clock, .srst, .link(link), .comm_enable, .engine_rpm,
		.target_rpm, .volts_tenths, .oil_kpa, .engine_temp,
		.engine_hours, .fuel_level, .state_code, .state_timer,
		.prestart1_req, .min_rpm_q, .max_rpm_q, .run_cmd_q,
		.auto_mode_q, .manual_only_q, .pre1_auto_only_q,
		.auto_active_q, .run_active_q, .prestart1_out_q, .save_pulse_q
	);
	cpm_device #(.TICK_CYCLES(TK)) cpm_device_flt_inst (
		.clock, .srst, .link(link_b), .comm_enable, .engine_rpm,
		.target_rpm, .volts_tenths, .oil_kpa, .engine_temp,
		.engine_hours, .fuel_level, .state_code, .state_timer,
		.prestart1_req, .min_rpm_q(min_rpm_b), .max_rpm_q(),
		.run_cmd_q(), .auto_mode_q(), .manual_only_q(),
		.pre1_auto_only_q(), .auto_active_q(), .run_active_q(),
		.prestart1_out_q(), .save_pulse_q()
	);
	cpm_host cpm_host_inst (
		.clock, .srst, .link(link), .cmd_valid, .cmd_pgn, .cmd_payload,
		.cmd_ready_q, .rx_strobe_q, .rx_pgn_q, .rx_payload_q
	);
	cpm_link_checker cpm_link_checker_inst (
		.clock, .srst, .d2h_valid(link.d2h_valid),
		.d2h_ready(link.d2h_ready), .d2h_id(link.d2h_id),
		.d2h_data(link.d2h_data), .h2d_valid(link.h2d_valid),
		.h2d_ready(link.h2d_ready), .h2d_id(link.h2d_id),
		.h2d_data(link.h2d_data)
	);
	// ==========
	// tasks
	task automatic chk(input string n, input logic [47:0] e,
		input logic [47:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic stall(input string n);
		errors++;
		$display("BAD %s exp done got timeout", n);
		report_and_stop();
	endtask : stall
	// one write through the remote end, then time for derived outputs
	task automatic wr(input cpm_pgn_type p, input cpm_payload_type d);
		int i;
		i = 0;
		while (cmd_ready_q !== 1'b1 && i < 100) begin
			@(negedge clock);
			i++;
		end
		if (i == 100)
			stall("cmd_ready");
		cmd_pgn = p;
		cmd_payload = d;
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		repeat (4) @(negedge clock);
	endtask : wr
	// raw frame on the second link; released lines show the inverse
	task automatic raw(input cpm_id_type id, input cpm_data_type d);
		int i;
		link_b.h2d_id = id;
		link_b.h2d_data = d;
		link_b.h2d_valid = 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (link_b.h2d_ready !== 1'b1 && i < 100);
		if (i == 100)
			stall("h2d_ready");
		@(negedge clock);
		link_b.h2d_valid = 1'b0;
		link_b.h2d_id = ~id;
		link_b.h2d_data = ~d;
		repeat (3) @(negedge clock);
	endtask : raw
	// ==========
	// sequence
	initial begin
		int i;
		link_b.d2h_ready = 1'b1;
		link_b.h2d_valid = 1'b0;
		link_b.h2d_id = '0;
		link_b.h2d_data = '0;
		repeat (4) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		chk("min", 16'h0000, min_rpm_q);
		chk("max", 16'hFFFF, max_rpm_q);
		chk("bits", 4'h0, {run_cmd_q, auto_mode_q,
			manual_only_q, pre1_auto_only_q});
		comm_enable = 1'b1;
		wr(`CPM_PGN_MIN_RPM, 48'h000000001234);
		chk("min", 16'h1234, min_rpm_q);
		wr(`CPM_PGN_MAX_RPM, 48'h000000000ABC);
		chk("max", 16'h0ABC, max_rpm_q);
		wr(`CPM_PGN_MODE, 48'h000000000001);
		chk("auto", 2'h3, {auto_mode_q, auto_active_q});
		wr(`CPM_PGN_RUN, 48'h000000000001);
		chk("run", 2'h3, {run_cmd_q, run_active_q});
		wr(`CPM_PGN_PRE1, 48'h000000000004);
		chk("pre1", 2'h3, {pre1_auto_only_q, prestart1_out_q});
		wr(`CPM_PGN_MAN_ONLY, 48'h000000000002);
		chk("lock", 5'h18, {manual_only_q, auto_mode_q,
			auto_active_q, run_active_q,
			prestart1_out_q});
		wr(`CPM_PGN_PRE1, 48'h000000000000);
		chk("pre1m", 1'b1, prestart1_out_q);
		prestart1_req = 1'b0;
		repeat (2) @(negedge clock);
		chk("pre1r", 1'b0, prestart1_out_q);
		prestart1_req = 1'b1;
		wr(`CPM_PGN_ANALOG, 48'hFFFFFFFFFFFF);
		chk("ro", 36'h12340ABCE, {min_rpm_q, max_rpm_q,
			run_cmd_q, auto_mode_q, manual_only_q, pre1_auto_only_q});
		$display("test settings done");
		wr(`CPM_PGN_SAVE, 48'h000000000001);
		chk("save", 1, saves);
		wr(`CPM_PGN_SAVE, 48'h000000000001);
		chk("save", 1, saves);
		wr(`CPM_PGN_SAVE, 48'h000000000000);
		wr(`CPM_PGN_SAVE, 48'h000000000001);
		chk("save", 2, saves);
		$display("test save done");
		comm_enable = 1'b0;
		repeat (3) @(negedge clock);
		rx_pgn.delete();
		rx_pay.delete();
		wr(`CPM_PGN_MIN_RPM, 48'h000000000777);
		repeat (TK + 20) @(negedge clock);
		chk("silent", 0, rx_pgn.size());
		chk("deaf", 16'h1234, min_rpm_q);
		comm_enable = 1'b1;
		i = 0;
		while (rx_pgn.size() < 10 && i < 200) begin
			@(negedge clock);
			i++;
		end
		if (i == 200)
			stall("burst");
		for (int k = 0; k < 10; k++)
			chk("pgn", 16'hFF90 + k, rx_pgn[k]);
		chk("speed", {target_rpm, engine_rpm}, rx_pay[0][31:0]);
		chk("min", 16'h1234, rx_pay[1][15:0]);
		chk("max", 16'h0ABC, rx_pay[2][15:0]);
		chk("analog", {engine_temp, oil_kpa, 16'h007D}, rx_pay[3]);
		chk("hours", {fuel_level, engine_hours}, rx_pay[4]);
		chk("state", {state_timer, state_code}, rx_pay[5][23:0]);
		chk("flags", 4'hE, {rx_pay[6][0], rx_pay[7][0],
			rx_pay[8][1], rx_pay[9][2]});
		chk("wire", {16'h007D, `CPM_TX_PFX1, `CPM_TX_PFX0},
			wire93[31:0]);
		repeat (TK - 20) @(negedge clock);
		chk("gap", 10, rx_pgn.size());
		repeat (25) @(negedge clock);
		chk("again", 20, rx_pgn.size());
		$display("test broadcast done");
		raw({5'h19, 16'hFF91, 8'h70}, 64'h11113C5B);
		raw({5'h18, 16'hFF91, 8'h71}, 64'h22223C5B);
		raw({5'h18, 16'hFF91, 8'h70}, 64'h33333C5A);
		chk("bad", 16'h0000, min_rpm_b);
		raw({5'h18, 16'hFF91, 8'h70}, 64'h44443C5B);
		chk("good", 16'h4444, min_rpm_b);
		$display("test faults done");
		report_and_stop();
	end
endmodule : can_parameter_message_map_tb
`default_nettype wire
